// ==== rtl/pcr_map.svh ====
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH

// byte offsets on the register bus, one aligned word each
`define PCR_OFS_CONTROL   8'h00
`define PCR_OFS_BANDWIDTH 8'h04
`define PCR_OFS_PROGRAM   8'h08

// pll_control field positions
`define PCR_CTL_IE_BIT    7
`define PCR_CTL_FLAG_BIT  6
`define PCR_CTL_PLL_ON_BIT 5
`define PCR_CTL_SRC_BIT    4
`define PCR_CTL_RSV_VAL   4'hf

// pll_bandwidth_control field positions
`define PCR_BW_AUTO_BIT   7
`define PCR_BW_LOCK_BIT   6
`define PCR_BW_TRACK_BIT  5
`define PCR_BW_LOSS_BIT   4

// reset values
`define PCR_RST_MUL       4'h6
`define PCR_RST_VRS       4'h6
`define PCR_RST_PLL_ENABLE     1'h1

// crystal loss check window: bus cycles per unit of the multiplier
`define PCR_LOSS_CYC_PER_N 6'h04

`endif

// ==== rtl/pcr_pkg.sv ====
package pcr_pkg;

  // pll_control storage
  typedef struct packed {
    logic ie;                       // lock interrupt enable
    logic flag;                     // lock change flag
    logic pll_on;                   // pll enable
    logic src_sel;                  // base clock source select
  } pcr_ctl_s;

  // pll_bandwidth_control storage
  typedef struct packed {
    logic       auto_bw;            // automatic bandwidth mode
    logic       track_manual;       // loop mode last written in manual mode
    logic       loss;               // crystal loss detect result
    logic [3:0] test;               // bandwidth test bits
  } pcr_bw_s;

  // pll_programming storage
  typedef struct packed {
    logic [3:0] mul;                // feedback multiplier code
    logic [3:0] vrs;                // vco range select
  } pcr_prog_s;

  // crystal loss check sequencer
  typedef enum logic {
    PCR_LOSS_IDLE,
    PCR_LOSS_RUN
  } pcr_loss_e;

endpackage : pcr_pkg

// ==== rtl/pcr_top.sv ====
// What this block does
// [RULE1] lock irq enable forced zero in manual
// [RULE2] lock toggle sets flag; flag and enable interrupt
// [RULE3] control register read or reset clears flag
// [RULE4] manual mode hides flag, lock, interrupt
// [RULE5] pll enable resets set, held by source
// [RULE6] source select needs pll on, range nonzero
// [RULE7] select picks vco or crystal halved, glitchless
// [RULE8] reset and stop clear source select
// [RULE9] control low nibble reads ones
// [RULE10] automatic bandwidth bit, read/write, reset clear
// [RULE11] lock read-only in auto, reset clear
// [RULE12] loop mode bit: status auto, control manual
// [RULE13] manual loop mode kept through auto
// [RULE14] crystal loss check over N times four
// [RULE15] software writes zero test bits
// [RULE16] multiplier code zero acts one, reset six
// [RULE17] programming register frozen while pll on
// [RULE18] range zero disables pll, reset six
// [RULE19] software enables pll before selecting vco
// [RULE20] software checks lock before selecting vco
// [RULE21] software clears loop mode before manual enable
// [RULE22] break without clear enable keeps flag
// [RULE23] analog status synchronised before use
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`include "pcr_map.svh"

module pcr_top (
  input  wire logic        CORE_CLK_IN,         // bus clock, 40 MHz
  input  wire logic        RESET_N_IN,          // synchronous reset, active low
  input  wire logic        WB_CYC_IN,           // wishbone cycle
  input  wire logic        WB_STB_IN,           // wishbone strobe
  input  wire logic        WB_WE_IN,            // wishbone write enable
  input  wire logic [7:0]  WB_ADR_IN,           // wishbone byte address
  input  wire logic [3:0]  WB_SEL_IN,           // wishbone byte selects
  input  wire logic [31:0] WB_DAT_IN,           // wishbone write data
  output logic      [31:0] WB_DAT_OUT,          // wishbone read data
  output logic             WB_ACK_OUT,          // wishbone acknowledge
  input  wire logic        LOCK_IN,             // lock detector, async
  input  wire logic        TRACK_IN,            // loop in tracking, async
  input  wire logic        XTAL_SEEN_IN,        // crystal activity seen, async
  input  wire logic        STOP_IN,             // stop instruction executing
  input  wire logic        BREAK_IN,            // break state active
  input  wire logic        BREAK_CLEAR_EN_IN,   // break clear enable
  output logic             PLL_ENABLE_OUT,      // pll and vco clock on
  output logic             BASE_CLK_SEL_OUT,    // 1 vco/2, 0 crystal/2
  output logic             AUTO_BW_OUT,         // automatic bandwidth mode
  output logic             TRACK_MODE_OUT,      // manual loop mode, 1 tracking
  output logic      [3:0]  FEEDBACK_MULT_OUT,   // effective multiplier N
  output logic      [3:0]  VCO_RANGE_OUT,       // range multiplier L
  output logic      [3:0]  BW_TEST_OUT,         // bandwidth test bits
  output logic             LOSS_CHECK_OUT,      // crystal loss check running
  output logic             CLOCKGEN_IRQ_OUT     // lock change interrupt
);

  pcr_pkg::pcr_ctl_s  ctl;                      // control register state
  pcr_pkg::pcr_bw_s   bw;                       // bandwidth register state
  pcr_pkg::pcr_prog_s prog;                     // programming register state
  pcr_pkg::pcr_ctl_s  next_ctl;                 // control next value
  pcr_pkg::pcr_bw_s   next_bw;                  // bandwidth next value
  pcr_pkg::pcr_prog_s next_prog;                // programming next value
  pcr_pkg::pcr_loss_e xstate;                   // crystal check state
  pcr_pkg::pcr_loss_e next_xstate;              // crystal check next state
  logic [5:0]         xcount;                   // crystal check cycles left
  logic [5:0]         next_xcount;              // crystal check count next
  logic               ack;                      // registered acknowledge
  logic [2:0]         sync_a;                   // synchroniser first stage
  logic [2:0]         sync_b;                   // synchroniser second stage
  logic               lock_prev;                // lock seen one cycle earlier

  // bus decode
  wire        acc       = WB_CYC_IN & WB_STB_IN;          // request present
  wire        take      = acc & ~ack;                     // first edge of a request
  wire        wr_now    = acc & ack & WB_WE_IN & WB_SEL_IN[0]; // write lands with ack
  wire        sel_ctl   = (WB_ADR_IN == `PCR_OFS_CONTROL);
  wire        sel_bw    = (WB_ADR_IN == `PCR_OFS_BANDWIDTH);
  wire        sel_prog  = (WB_ADR_IN == `PCR_OFS_PROGRAM);
  wire        wr_ctl    = wr_now & sel_ctl;
  wire        wr_bw     = wr_now & sel_bw;
  wire        wr_prog   = wr_now & sel_prog;
  wire        rd_ctl    = take & ~WB_WE_IN & sel_ctl;     // read part of rmw counts too
  wire [7:0]  wd        = WB_DAT_IN[7:0];

  // synchronised analog status
  wire        lock_s    = sync_b[0];
  wire        track_s   = sync_b[1];
  wire        xtal_s    = sync_b[2];
  wire        lock_tog  = lock_s ^ lock_prev;

  // flag protection during break
  wire        keep_flag = BREAK_IN & ~BREAK_CLEAR_EN_IN;
  wire        clr_flag  = rd_ctl & ~keep_flag;  // [RULE3] [RULE22]

  // vco may be chosen only with the loop on and a legal range
  wire        vco_ok    = ctl.pll_on & (prog.vrs != 4'h0);  // [RULE6] [RULE18]
  wire        loss_go   = wr_bw & wd[`PCR_BW_LOSS_BIT] & ctl.src_sel;  // [RULE14]
  wire [3:0]  n_eff     = (prog.mul == 4'h0) ? 4'h1 : prog.mul;  // [RULE16]
  wire [5:0]  xwin      = {2'h0, n_eff} * `PCR_LOSS_CYC_PER_N;

  // read values; hidden fields read as zero in manual mode
  wire [7:0]  rd_ctl_val  = {ctl.ie & bw.auto_bw,
                             ctl.flag & bw.auto_bw,  // [RULE4]
                             ctl.pll_on,
                             ctl.src_sel,
                             `PCR_CTL_RSV_VAL};  // [RULE9]
  wire        track_rd    = bw.auto_bw ? track_s : bw.track_manual;  // [RULE12]
  wire [7:0]  rd_bw_val   = {bw.auto_bw,
                             bw.auto_bw & lock_s,  // [RULE11] [RULE4]
                             track_rd,
                             bw.loss & ctl.src_sel,  // [RULE14]
                             bw.test};
  wire [7:0]  rd_val      = sel_ctl  ? rd_ctl_val :
                            sel_bw   ? rd_bw_val :
                            sel_prog ? {prog.mul, prog.vrs} : 8'h00;

  // next state of pll_control
  always_comb begin
    next_ctl = ctl;
    // enable only exists in automatic mode
    if (!bw.auto_bw) begin
      next_ctl.ie = 1'b0;  // [RULE1]
    end else if (wr_ctl) begin
      next_ctl.ie = wd[`PCR_CTL_IE_BIT];
    end
    // set wins over a clearing read in the same cycle
    next_ctl.flag = lock_tog | (ctl.flag & ~clr_flag);  // [RULE2] [RULE3]
    // old source select decides, so on and select cannot change together
    if (ctl.src_sel) begin
      next_ctl.pll_on = 1'b1;  // [RULE5]
    end else if (wr_ctl) begin
      next_ctl.pll_on = wd[`PCR_CTL_PLL_ON_BIT];
    end
    // a write that turns the loop off can never select the vco with it
    if (STOP_IN || !vco_ok || !next_ctl.pll_on) begin
      next_ctl.src_sel = 1'b0;  // [RULE6] [RULE8] [RULE18]
    end else if (wr_ctl) begin
      next_ctl.src_sel = wd[`PCR_CTL_SRC_BIT];  // [RULE7]
    end
  end

  // next state of pll_bandwidth_control
  always_comb begin
    next_bw = bw;
    if (wr_bw) begin
      next_bw.auto_bw = wd[`PCR_BW_AUTO_BIT];  // [RULE10]
      next_bw.test    = wd[3:0];
    end
    // writes in automatic mode do not touch the stored manual value
    if (wr_bw && !bw.auto_bw) begin
      next_bw.track_manual = wd[`PCR_BW_TRACK_BIT];  // [RULE12] [RULE13]
    end
    // crystal check: written one starts, activity during window clears
    if (loss_go) begin
      next_bw.loss = 1'b1;  // [RULE14]
    end else if (wr_bw) begin
      next_bw.loss = 1'b0;
    end else if (xstate == pcr_pkg::PCR_LOSS_RUN && xtal_s) begin
      next_bw.loss = 1'b0;
    end
  end

  // crystal check window sequencer
  always_comb begin
    next_xstate = xstate;
    next_xcount = xcount;
    unique case (xstate)
      pcr_pkg::PCR_LOSS_IDLE: begin
        if (loss_go) begin
          next_xstate = pcr_pkg::PCR_LOSS_RUN;
          next_xcount = xwin - 6'h01;
        end
      end
      pcr_pkg::PCR_LOSS_RUN: begin
        // leaving vco source aborts the check, the bit reads zero anyway
        if (xcount == 6'h00 || !ctl.src_sel) begin
          next_xstate = pcr_pkg::PCR_LOSS_IDLE;
        end else begin
          next_xcount = xcount - 6'h01;
        end
      end
    endcase
  end

  // programming register, frozen while the pll runs
  always_comb begin
    next_prog = prog;
    if (wr_prog && !ctl.pll_on) begin
      next_prog = {wd[7:4], wd[3:0]};  // [RULE17]
    end
  end

  // two-flop synchroniser for the analog status lines
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      sync_a    <= 3'h0;
      sync_b    <= 3'h0;
      lock_prev <= 1'b0;
    end else begin
      sync_a    <= {XTAL_SEEN_IN, TRACK_IN, LOCK_IN};  // [RULE23]
      sync_b    <= sync_a;
      lock_prev <= lock_s;
    end
  end

  // register state
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      ctl    <= '{ie: 1'b0, flag: 1'b0, pll_on: `PCR_RST_PLL_ENABLE, src_sel: 1'b0};
      bw     <= '0;
      prog   <= '{mul: `PCR_RST_MUL, vrs: `PCR_RST_VRS};
      xstate <= pcr_pkg::PCR_LOSS_IDLE;
      xcount <= 6'h00;
    end else begin
      ctl    <= next_ctl;
      bw     <= next_bw;
      prog   <= next_prog;
      xstate <= next_xstate;
      xcount <= next_xcount;
    end
  end

  // bus answer: ack one cycle after the request, data captured then
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      ack        <= 1'b0;
      WB_DAT_OUT <= 32'h0;
    end else begin
      ack <= take;
      if (take && !WB_WE_IN) begin
        WB_DAT_OUT <= {24'h0, rd_val};
      end
    end
  end

  // outputs registered from next values so they match the state
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RESET_N_IN) begin
      WB_ACK_OUT        <= 1'b0;
      PLL_ENABLE_OUT    <= 1'b1;
      BASE_CLK_SEL_OUT  <= 1'b0;
      AUTO_BW_OUT       <= 1'b0;
      TRACK_MODE_OUT    <= 1'b0;
      FEEDBACK_MULT_OUT <= `PCR_RST_MUL;
      VCO_RANGE_OUT     <= `PCR_RST_VRS;
      BW_TEST_OUT       <= 4'h0;
      LOSS_CHECK_OUT    <= 1'b0;
      CLOCKGEN_IRQ_OUT  <= 1'b0;
    end else begin
      WB_ACK_OUT        <= take;
      // range zero keeps the loop off whatever the enable says
      PLL_ENABLE_OUT    <= next_ctl.pll_on & (next_prog.vrs != 4'h0);  // [RULE18]
      // external selector holds its output static while it switches
      BASE_CLK_SEL_OUT  <= next_ctl.src_sel;  // [RULE7]
      AUTO_BW_OUT       <= next_bw.auto_bw;
      TRACK_MODE_OUT    <= next_bw.track_manual;  // [RULE12]
      FEEDBACK_MULT_OUT <= (next_prog.mul == 4'h0) ? 4'h1 : next_prog.mul;  // [RULE16]
      VCO_RANGE_OUT     <= next_prog.vrs;
      BW_TEST_OUT       <= next_bw.test;
      LOSS_CHECK_OUT    <= (next_xstate == pcr_pkg::PCR_LOSS_RUN);
      CLOCKGEN_IRQ_OUT  <= next_ctl.flag & next_ctl.ie & next_bw.auto_bw;  // [RULE2] [RULE4]
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence s_req;
    acc && !ack;
  endsequence

  sequence s_answer;
    WB_ACK_OUT ##1 !WB_ACK_OUT;
  endsequence

  sequence s_loss_start;
    loss_go && (n_eff == 4'h2);
  endsequence

  sequence s_bw_read;
    take && !WB_WE_IN && sel_bw;
  endsequence

  sequence s_leave_auto;
    wr_bw && bw.auto_bw && !wd[`PCR_BW_AUTO_BIT];
  endsequence

  // register access checks
  a_bus_ack_once: assert property (s_req |=> s_answer)
    else $error("ack not a single cycle after request");

  a_ie_manual_off: assert property (!bw.auto_bw |=> !ctl.ie) // [RULE1]
    else $error("interrupt enable not forced off in manual");

  a_ie_write_auto: assert property (wr_ctl && bw.auto_bw |=> // [RULE1]
                                    ctl.ie == $past(wd[`PCR_CTL_IE_BIT]))
    else $error("interrupt enable write lost in auto");

  a_auto_write: assert property (wr_bw |=> // [RULE10]
                                 bw.auto_bw == $past(wd[`PCR_BW_AUTO_BIT]))
    else $error("automatic bandwidth write lost");

  a_prog_write: assert property (wr_prog && !ctl.pll_on |=> prog == $past(wd)) // [RULE17]
    else $error("programming write lost while pll off");

  a_lock_read: assert property (s_bw_read |=> // [RULE11]
                                WB_DAT_OUT[`PCR_BW_LOCK_BIT] == $past(bw.auto_bw && lock_s))
    else $error("lock bit read wrong");

  a_track_status: assert property (s_bw_read ##0 bw.auto_bw |=> // [RULE12]
                                   WB_DAT_OUT[`PCR_BW_TRACK_BIT] == $past(track_s))
    else $error("loop mode status not read in auto");

  a_track_stored: assert property (s_bw_read ##0 !bw.auto_bw |=> // [RULE12] [RULE13]
                                   WB_DAT_OUT[`PCR_BW_TRACK_BIT] == $past(bw.track_manual))
    else $error("stored loop mode not read back in manual");

  a_auto_restore: assert property (s_leave_auto |=> TRACK_MODE_OUT == $past(bw.track_manual)) // [RULE13]
    else $error("loop mode not restored on leaving auto");

  // status path checks
  a_sync_two: assert property ($past(RESET_N_IN) && $past(RESET_N_IN, 2) |-> // [RULE23]
                               lock_s == $past(LOCK_IN, 2))
    else $error("lock status not two flops behind its pin");

  a_flag_on_toggle: assert property ($changed(lock_s) |=> ctl.flag) // [RULE2]
    else $error("lock toggle did not set flag");

  a_flag_set_wins: assert property (lock_tog && rd_ctl |=> ctl.flag) // [RULE2] [RULE3]
    else $error("clearing read beat a lock toggle");

  a_irq_matches: assert property (CLOCKGEN_IRQ_OUT == (ctl.flag && ctl.ie && bw.auto_bw)) // [RULE2]
    else $error("interrupt output disagrees with flag and enable");

  a_read_clears: assert property (rd_ctl && !keep_flag && !lock_tog |=> !ctl.flag) // [RULE3]
    else $error("control read did not clear flag");

  a_break_keeps: assert property (rd_ctl && keep_flag && ctl.flag |=> ctl.flag) // [RULE22]
    else $error("flag lost during protected break");

  a_manual_hides: assert property (!bw.auto_bw |-> !rd_ctl_val[6] && !rd_bw_val[6] // [RULE4]
                                   && !CLOCKGEN_IRQ_OUT)
    else $error("manual mode shows flag, lock or interrupt");

  // interlock checks
  a_src_holds_on: assert property (ctl.src_sel |-> ctl.pll_on ##1 ctl.pll_on) // [RULE5]
    else $error("pll enable cleared while vco selected");

  a_src_needs_pll: assert property ((!ctl.pll_on || prog.vrs == 4'h0) |=> !ctl.src_sel) // [RULE6]
    else $error("source select set without pll on and range");

  a_on_off_apart: assert property ($changed(ctl.pll_on) |-> !$changed(ctl.src_sel)) // [RULE5] [RULE6]
    else $error("pll enable and source select changed together");

  a_sel_follows: assert property (BASE_CLK_SEL_OUT == ctl.src_sel) // [RULE7]
    else $error("source select output disagrees with register");

  a_range_gates: assert property (PLL_ENABLE_OUT == // [RULE18]
                                  (ctl.pll_on && prog.vrs != 4'h0))
    else $error("pll enable output not gated by range");

  a_stop_clears: assert property (STOP_IN |=> !ctl.src_sel ##1 !BASE_CLK_SEL_OUT) // [RULE8]
    else $error("stop did not return to crystal source");

  a_rsv_ones: assert property (rd_ctl |=> WB_DAT_OUT[3:0] == `PCR_CTL_RSV_VAL) // [RULE9]
    else $error("control low nibble not read as ones");

  a_prog_frozen: assert property (ctl.pll_on |=> $stable(prog)) // [RULE17]
    else $error("programming register changed while pll on");

  a_manual_kept: assert property (bw.auto_bw |=> $stable(bw.track_manual)) // [RULE13]
    else $error("stored manual loop mode changed in auto");

  a_mult_floor: assert property (FEEDBACK_MULT_OUT != 4'h0) // [RULE16]
    else $error("multiplier output zero");

  a_mult_out: assert property (FEEDBACK_MULT_OUT == n_eff) // [RULE16]
    else $error("multiplier output not the effective code");

  a_loss_hidden: assert property (!ctl.src_sel |-> !rd_bw_val[`PCR_BW_LOSS_BIT]) // [RULE14]
    else $error("crystal loss bit visible on crystal source");

  a_loss_window: assert property (s_loss_start |=> LOSS_CHECK_OUT [*8] // [RULE14]
                                  ##1 !LOSS_CHECK_OUT)
    else $error("crystal check window not eight cycles for N of two");

endmodule : pcr_top

// ==== tb/pcr_loop_model.sv ====
// analog side of the clock generator: lock detector, loop mode and crystal activity
module pcr_loop_model #(
  parameter int SETTLE_CYC = 3               // cycles the loop needs to settle
) (
  input  wire logic clk_in,                  // bus clock
  input  wire logic lock_req_in,             // bench asks the loop to gain or lose lock
  input  wire logic xtal_ok_in,              // crystal running
  output logic      lock_out,                // lock detector level
  output logic      track_out,               // loop in tracking mode
  output logic      xtal_seen_out            // crystal activity, toggles while running
);
  int cnt;                                   // settle counter

  initial begin
    lock_out = 1'b0;
    track_out = 1'b0;
    xtal_seen_out = 1'b0;
    cnt = 0;
  end

  // lock follows the request only after a settle time, so the bench never sees it early
  always @(posedge clk_in) begin
    if (lock_req_in != lock_out) begin
      cnt <= cnt + 1;
      if (cnt >= SETTLE_CYC - 1) begin
        lock_out <= lock_req_in;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
    track_out <= lock_out;                   // tracking is entered one cycle after lock
    xtal_seen_out <= xtal_ok_in ? ~xtal_seen_out : 1'b0;  // a dead crystal shows no edges
  end
endmodule : pcr_loop_model

// ==== tb/pcr_top_tb_top.sv ====
`include "pcr_map.svh"

module pcr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ctl_a = `PCR_OFS_CONTROL;
  localparam logic [7:0] bw_a  = `PCR_OFS_BANDWIDTH;
  localparam logic [7:0] pg_a  = `PCR_OFS_PROGRAM;
  logic        clk, rst_n, cyc, stb, we, stop, brk, brk_en, lock_req, xtal_ok;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  wire logic [31:0] dat_out;
  wire logic   ack, lock, track, seen, pll_en, sel, auto_bw, trk, loss_act, irq;
  wire logic [3:0] mult, rng, tst;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc_cnt = 0;
  int          n;

  pcr_top i_dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'h1), .WB_DAT_IN(wdat), .WB_DAT_OUT(dat_out),
    .WB_ACK_OUT(ack), .LOCK_IN(lock), .TRACK_IN(track), .XTAL_SEEN_IN(seen), .STOP_IN(stop),
    .BREAK_IN(brk), .BREAK_CLEAR_EN_IN(brk_en), .PLL_ENABLE_OUT(pll_en),
    .BASE_CLK_SEL_OUT(sel), .AUTO_BW_OUT(auto_bw), .TRACK_MODE_OUT(trk),
    .FEEDBACK_MULT_OUT(mult), .VCO_RANGE_OUT(rng), .BW_TEST_OUT(tst),
    .LOSS_CHECK_OUT(loss_act), .CLOCKGEN_IRQ_OUT(irq));

  pcr_loop_model i_loop (.clk_in(clk), .lock_req_in(lock_req), .xtal_ok_in(xtal_ok),
    .lock_out(lock), .track_out(track), .xtal_seen_out(seen));

  task automatic final_report;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one classic cycle: request held until ack is sampled high, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    // only the bench timeout ends a wait for an answer that never comes
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    rdat = dat_out;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
    @(negedge clk);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(nm, rdat, {24'h000000, e});
  endtask : rd

  // bounded wait for the lock interrupt
  task automatic wait_irq;
    int t = 0;
    while (irq !== 1'b1 && t < 40) begin
      t++;
      @(negedge clk);
    end
  endtask : wait_irq

  // free running bus clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 4000) begin
      n_mismatch++;
      final_report;
    end
  end

  initial begin
    {rst_n, cyc, stb, we, stop, brk, brk_en, lock_req} = 8'h00;
    xtal_ok = 1'b1;
    adr = 8'h00;
    wdat = 32'h00000000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd("ctl_reset", ctl_a, 8'h2f);
    rd("bw_reset", bw_a, 8'h00);
    rd("pg_reset", pg_a, 8'h66);
    rd("unmapped", 8'h0c, 8'h00);
    chk("pll_en", pll_en, 1'b1);
    wr(pg_a, 8'h11);
    rd("pg_frozen", pg_a, 8'h66);
    wr(ctl_a, 8'h00);
    chk("pll_off", pll_en, 1'b0);
    wr(ctl_a, 8'h10);
    rd("sel_blocked", ctl_a, 8'h0f);
    wr(pg_a, 8'h00);
    chk("mult_zero", mult, 4'h1);
    wr(bw_a, 8'h00);
    wr(ctl_a, 8'h20);
    chk("range_zero", pll_en, 1'b0);
    wr(ctl_a, 8'h30);
    rd("sel_range0", ctl_a, 8'h2f);
    wr(ctl_a, 8'h00);
    wr(pg_a, 8'h25);
    wr(ctl_a, 8'h20);
    chk("mult_two", {rng, mult}, 8'h52);
    wr(ctl_a, 8'ha0);
    rd("ie_manual", ctl_a, 8'h2f);
    lock_req <= 1'b1;
    repeat (12) @(negedge clk);
    rd("lock_manual", bw_a, 8'h00);
    rd("flag_manual", ctl_a, 8'h2f);
    chk("irq_manual", irq, 1'b0);
    wr(bw_a, 8'h20);
    chk("trk_manual", trk, 1'b1);
    wr(bw_a, 8'ha0);
    rd("bw_auto", bw_a, 8'he0);
    chk("trk_kept", {auto_bw, trk, tst}, 6'h30);
    wr(ctl_a, 8'ha0);
    rd("ie_auto", ctl_a, 8'haf);
    wr(ctl_a, 8'hb0);
    chk("sel_vco", sel, 1'b1);
    wr(ctl_a, 8'h90);
    rd("pll_held", ctl_a, 8'hbf);
    lock_req <= 1'b0;
    wait_irq;
    chk("irq_set", irq, 1'b1);
    rd("flag_set", ctl_a, 8'hff);
    @(negedge clk);
    chk("irq_clr", irq, 1'b0);
    rd("flag_clr", ctl_a, 8'hbf);
    brk <= 1'b1;
    lock_req <= 1'b1;
    wait_irq;
    rd("brk_rd1", ctl_a, 8'hff);
    rd("brk_rd2", ctl_a, 8'hff);
    brk <= 1'b0;
    rd("brk_off", ctl_a, 8'hff);
    rd("brk_clr", ctl_a, 8'hbf);
    // break with clearing allowed: the read clears the flag as usual
    brk_en <= 1'b1;
    brk <= 1'b1;
    lock_req <= 1'b0;
    wait_irq;
    rd("brk_en_rd", ctl_a, 8'hff);
    rd("brk_en_clr", ctl_a, 8'hbf);
    brk <= 1'b0;
    brk_en <= 1'b0;
    lock_req <= 1'b1;
    wait_irq;
    rd("relock", ctl_a, 8'hff);
    xtal_ok <= 1'b0;
    repeat (4) @(negedge clk);
    wr(bw_a, 8'h90);
    n = 0;
    while (loss_act === 1'b1 && n < 100) begin
      n++;
      @(negedge clk);
    end
    chk("loss_window", n, 8);
    rd("loss_seen", bw_a, 8'hf0);
    xtal_ok <= 1'b1;
    wr(bw_a, 8'h90);
    repeat (12) @(negedge clk);
    rd("loss_clear", bw_a, 8'he0);
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    @(negedge clk);
    chk("stop_sel", sel, 1'b0);
    rd("stop_ctl", ctl_a, 8'haf);
    wr(bw_a, 8'h00);
    rd("ie_forced", ctl_a, 8'h2f);
    final_report;
  end
endmodule : pcr_top_tb_top
